// [hw/ubfs_uart_setup.v]
// How it works
// R1: Each bit lasts sixteen baud ticks.
// R2: Fraction adds sixty-fourths to the divisor.
// R3: Divisor high at 1, low at 0.
// R4: Key 0xBF on line control maps enhanced reg.
// R5: Enhanced bit 4 enables fractional divisor.
// R6: Divisor latch bit exposes divisor and fraction.
// R7: Fraction register sits at address 7.
// R8: Queue control resets and enables FIFOs.
// R9: Holding writes enter FIFO, then shift out; code drops them while the FIFO is disabled.
// R10: Host sets divisor, format, then resets FIFOs.
// R11: Other line values restore normal map; divisor kept.
`timescale 1ns/10ps
`default_nettype none
`include "ubfs_regs.vh"

module ubfs_uart_setup (
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output reg serial_tx
);

// ****************************************************************************
// Bus slave: one wait cycle per access
// ****************************************************************************
reg ack;
wire req = (avs_read | avs_write) & clk_en;
assign avs_waitrequest = (avs_read | avs_write) & ~ack;
wire [2:0] idx = avs_address[4:2];
wire wr_go = avs_write & ack & clk_en & avs_byteenable[0];
wire [7:0] wdat = avs_writedata[7:0];

reg [7:0] div_low;
reg [7:0] div_high;
reg [7:0] div_frac;
reg [7:0] enh_ctrl;
reg [7:0] line_ctrl;
reg fifo_on;

wire key_held = (line_ctrl == `UBFS_KEY_ENHANCED);
wire dlab = line_ctrl[`UBFS_LINE_DLAB_BIT] & ~key_held;
wire frac_on = enh_ctrl[`UBFS_EFR_ENH_BIT];

// ****************************************************************************
// Address decode
// ****************************************************************************
// Decode used by both the read and the write path
function [2:0] ubfs_sel;
    input [2:0] a;
    input kh;
    input dl;
    begin
        if (kh && a == `UBFS_IDX_SHARED2) begin
            ubfs_sel = 3'h1;
        end else if ((kh || dl) && a == `UBFS_IDX_HOLD) begin
            ubfs_sel = 3'h2;
        end else if ((kh || dl) && a == `UBFS_IDX_DIV_HIGH) begin
            ubfs_sel = 3'h3;
        end else if (dl && a == `UBFS_IDX_FRACTION) begin
            ubfs_sel = 3'h4;
        end else begin
            ubfs_sel = 3'h0;
        end
    end
endfunction

wire [2:0] sel = ubfs_sel(idx, key_held, dlab);

// ****************************************************************************
// Transmit FIFO
// ****************************************************************************
reg [7:0] fifo_mem [0:`UBFS_FIFO_DEPTH-1];
reg [`UBFS_FIFO_AW:0] wr_ptr;
reg [`UBFS_FIFO_AW:0] rd_ptr;
wire fifo_empty = (wr_ptr == rd_ptr);
wire fifo_full = (wr_ptr[`UBFS_FIFO_AW] != rd_ptr[`UBFS_FIFO_AW]) &&
    (wr_ptr[`UBFS_FIFO_AW-1:0] == rd_ptr[`UBFS_FIFO_AW-1:0]);
wire hold_wr = wr_go && sel == 3'h0 && idx == `UBFS_IDX_HOLD;
wire qc_wr = wr_go && sel == 3'h0 && idx == `UBFS_IDX_SHARED2;
wire tx_reset = qc_wr && (wdat[`UBFS_QC_TXRST_BIT] || wdat[`UBFS_QC_RXRST_BIT]);
reg tx_busy;
wire tx_load = fifo_on && !fifo_empty && !tx_busy && !tx_reset;
wire push = hold_wr && fifo_on && !fifo_full && !tx_reset; // R9

// ****************************************************************************
// Write strobes, one per register
// ****************************************************************************
wire enh_wr = wr_go && sel == 3'h1; // R4 R5
wire low_wr = wr_go && sel == 3'h2; // R3
wire high_wr = wr_go && sel == 3'h3; // R3
wire frac_wr = wr_go && sel == 3'h4; // R7
wire line_wr = wr_go && sel == 3'h0 && idx == `UBFS_IDX_LINE; // R6 R11

// ****************************************************************************
// Bus handshake: acknowledge in the cycle after a request
// ****************************************************************************
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        ack <= 1'b0;
    end else if (clk_en) begin
        ack <= req & ~ack;
    end
end

// ****************************************************************************
// Registers
// ****************************************************************************
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        enh_ctrl <= 8'h00;
    end else if (clk_en && enh_wr) begin
        enh_ctrl <= wdat; // R4 R5
    end
end

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        div_low <= 8'h00;
    end else if (clk_en && low_wr) begin
        div_low <= wdat; // R3
    end
end

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        div_high <= 8'h00;
    end else if (clk_en && high_wr) begin
        div_high <= wdat; // R3
    end
end

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        div_frac <= 8'h00;
    end else if (clk_en && frac_wr) begin
        div_frac <= {2'b00, wdat[5:0]}; // R7
    end
end

// Leaving the key value restores the normal map; divisors stay
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        line_ctrl <= `UBFS_LINE_RESET;
    end else if (clk_en && line_wr) begin
        line_ctrl <= wdat; // R6 R11
    end
end

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        fifo_on <= 1'b0;
    end else if (clk_en && qc_wr) begin
        fifo_on <= wdat[`UBFS_QC_ENABLE_BIT]; // R8
    end
end

// ****************************************************************************
// Transmit FIFO pointers
// ****************************************************************************
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        wr_ptr <= 4'h0;
        rd_ptr <= 4'h0;
    end else if (clk_en) begin
        if (tx_reset) begin
            wr_ptr <= 4'h0; // R8
            rd_ptr <= 4'h0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 4'h1; // R9
            end
            if (tx_load) begin
                rd_ptr <= rd_ptr + 4'h1;
            end
        end
    end
end

// ****************************************************************************
// Transmit FIFO storage
// ****************************************************************************
always @(posedge core_clk) begin
    if (clk_en && push) begin
        fifo_mem[wr_ptr[`UBFS_FIFO_AW-1:0]] <= wdat; // R9
    end
end

// ****************************************************************************
// Read data
// ****************************************************************************
reg [7:0] next_readdata;

always @* begin
    next_readdata = 8'h00;
    case (sel)
        3'h1: begin
            next_readdata = enh_ctrl; // R4
        end
        3'h2: begin
            next_readdata = div_low; // R3
        end
        3'h3: begin
            next_readdata = div_high; // R3
        end
        3'h4: begin
            next_readdata = div_frac; // R7
        end
        default: begin
            if (idx == `UBFS_IDX_LINE) begin
                next_readdata = line_ctrl; // R11
            end else if (idx == `UBFS_IDX_STATUS) begin
                next_readdata = {4'h0, fifo_full, fifo_on, tx_busy, fifo_empty};
            end
        end
    endcase
end

// Data stands from the wait cycle until the next read is taken
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        avs_readdata <= 32'h0000_0000;
    end else if (clk_en && avs_read && !ack) begin
        avs_readdata <= {24'h00_0000, next_readdata};
    end
end

// ****************************************************************************
// Baud generator: divisor plus fraction/64, 16 ticks per bit
// ****************************************************************************
reg [15:0] baud_cnt;
reg [6:0] frac_acc;
wire [15:0] divisor = {div_high, div_low};
wire [6:0] frac_sum = frac_acc + {1'b0, (frac_on ? div_frac[5:0] : 6'h00)}; // R2 R5
wire frac_carry = frac_sum >= `UBFS_FRAC_STEPS;
wire baud_tick = (divisor != 16'h0000) && (baud_cnt == 16'h0000);
reg [3:0] os_cnt;
wire bit_tick = baud_tick && os_cnt == 4'hF; // R1

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        baud_cnt <= 16'h0000;
    end else if (clk_en) begin
        if (divisor == 16'h0000) begin
            baud_cnt <= 16'h0000;
        end else if (baud_tick) begin
            // Fraction stretches one tick in every carry
            if (frac_carry) begin
                baud_cnt <= divisor; // R2
            end else begin
                baud_cnt <= divisor - 16'h0001;
            end
        end else begin
            baud_cnt <= baud_cnt - 16'h0001;
        end
    end
end

// ****************************************************************************
// Fractional accumulator: sixty-fourths carried into the next tick
// ****************************************************************************
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        frac_acc <= 7'h00;
    end else if (clk_en && baud_tick) begin
        if (frac_carry) begin
            frac_acc <= frac_sum - `UBFS_FRAC_STEPS; // R2
        end else begin
            frac_acc <= frac_sum;
        end
    end
end

// ****************************************************************************
// Oversampling counter: sixteen ticks make one bit
// ****************************************************************************
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        os_cnt <= 4'h0;
    end else if (clk_en) begin
        if (divisor == 16'h0000) begin
            os_cnt <= 4'h0;
        end else if (baud_tick) begin
            os_cnt <= os_cnt + 4'h1; // R1
        end
    end
end

// ****************************************************************************
// Transmit shifter: 8N1 frame
// ****************************************************************************
reg [9:0] shift;
reg [3:0] bit_cnt;
wire frame_end = tx_busy && bit_tick && bit_cnt == 4'hA;

always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        tx_busy <= 1'b0;
        shift <= 10'h3FF;
        bit_cnt <= 4'h0;
    end else if (clk_en) begin
        if (tx_load) begin
            tx_busy <= 1'b1; // R9
            shift <= {1'b1, fifo_mem[rd_ptr[`UBFS_FIFO_AW-1:0]], 1'b0};
            bit_cnt <= 4'h0;
        end else if (tx_busy && bit_tick) begin
            shift <= {1'b1, shift[9:1]};
            if (frame_end) begin
                tx_busy <= 1'b0;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end
end

// ****************************************************************************
// Serial output: idles high between frames
// ****************************************************************************
always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
        serial_tx <= 1'b1;
    end else if (clk_en) begin
        if (frame_end) begin
            serial_tx <= 1'b1;
        end else if (tx_busy && bit_tick) begin
            serial_tx <= shift[0]; // R1
        end
    end
end

endmodule // ubfs_uart_setup
`default_nettype wire

// [hw/ubfs_regs.vh]
`ifndef UBFS_REGS_VH
`define UBFS_REGS_VH

// ****************************************************************************
// Local register addresses (register index; byte address is four times it)
// ****************************************************************************
`define UBFS_IDX_HOLD 3'h0
`define UBFS_IDX_DIV_HIGH 3'h1
`define UBFS_IDX_SHARED2 3'h2
`define UBFS_IDX_LINE 3'h3
`define UBFS_IDX_STATUS 3'h5
`define UBFS_IDX_FRACTION 3'h7

// ****************************************************************************
// Key values and commands
// ****************************************************************************
`define UBFS_KEY_ENHANCED 8'hBF
`define UBFS_LINE_RESET 8'h03
`define UBFS_EFR_ENH_BIT 4
`define UBFS_LINE_DLAB_BIT 7
`define UBFS_QC_ENABLE_BIT 0
`define UBFS_QC_RXRST_BIT 1
`define UBFS_QC_TXRST_BIT 2

// ****************************************************************************
// Baud generation and FIFO size
// ****************************************************************************
`define UBFS_OVERSAMPLE 5'h10
`define UBFS_FRAC_STEPS 7'h40
`define UBFS_FIFO_DEPTH 8
`define UBFS_FIFO_AW 3

`endif

// [verification/ubfs_uart_setup_props.sv]
`timescale 1ns/10ps
`default_nettype none
module ubfs_uart_setup_props (
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire serial_tx
);
    // ********************
    // Bus and line checks
    // ********************
    wire req = avs_read | avs_write;
    wire ack_rd = avs_read & ~avs_waitrequest;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    a_one_wait: assert property (req && avs_waitrequest && clk_en |=> !avs_waitrequest)
        else $error("no answer");
    a_wait_cause: assert property (avs_waitrequest |-> req) else $error("stray wait");
    a_each_two: assert property ((req && !avs_waitrequest) ##1 req |-> avs_waitrequest)
        else $error("no wait state");
    a_upper_zero: assert property (avs_readdata[31:8] == 24'h00_0000)
        else $error("upper bits set");
    a_data_stands: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved");
    a_hole_zero: assert property (ack_rd && avs_address[4:2] == 3'h4 |-> avs_readdata == 0)
        else $error("hole not zero");
    a_frac_width: assert property (ack_rd && avs_address[4:2] == 3'h7 |-> avs_readdata[7:6] == 0)
        else $error("fraction too wide");
    a_bit_hold: assert property ($changed(serial_tx) |=> $stable(serial_tx) [*8])
        else $error("bit too short");
endmodule // ubfs_uart_setup_props
bind ubfs_uart_setup ubfs_uart_setup_props i_ubfs_uart_setup_props (.core_clk(core_clk),
    .arst_n(arst_n), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_tx(serial_tx));
`default_nettype wire

// [verification/ubfs_line_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module ubfs_line_monitor #(parameter int BIT_CLKS = 2500) (
    input wire logic core_clk,
    input wire logic serial_tx,
    output logic [7:0] rx_byte,
    output logic stop_bit,
    output int frames,
    output int last_rise
);
    // ********************
    // Frame capture
    // ********************
    int n;
    always @(posedge serial_tx) last_rise = n;
    initial begin
        rx_byte = 8'h00;
        frames = 0;
        n = 0;
        forever begin
            @(negedge serial_tx);
            for (n = 0; n < 9 * BIT_CLKS + BIT_CLKS / 2; n++) begin
                @(posedge core_clk);
                if (n > BIT_CLKS && n % BIT_CLKS == BIT_CLKS / 2)
                    rx_byte = {serial_tx, rx_byte[7:1]};
            end
            stop_bit = serial_tx;
            frames++;
        end
    end
endmodule // ubfs_line_monitor
`default_nettype wire

// [verification/ubfs_uart_setup_test.sv]
`timescale 1ns/10ps
`default_nettype none
module ubfs_uart_setup_test;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, r;
    logic avs_waitrequest, serial_tx, stop_bit;
    logic [7:0] rx_byte;
    int frames, last_rise, k;
    int errors = 0;
    int total_checks = 0;
    // ********************
    // Bench
    // ********************
    always #25 core_clk = ~core_clk;
    ubfs_uart_setup i_ubfs_uart_setup (.core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .serial_tx(serial_tx));
    ubfs_line_monitor #(.BIT_CLKS(2500)) i_ubfs_line_monitor (.core_clk(core_clk),
        .serial_tx(serial_tx), .rx_byte(rx_byte), .stop_bit(stop_bit), .frames(frames),
        .last_rise(last_rise));
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Reads compare the masked data with d; request is held, released by the caller
    task automatic bus(input logic rd, input logic [2:0] idx, input logic [7:0] d,
        input logic [7:0] m = 8'hFF);
        avs_address <= {idx, 2'h0};
        avs_writedata <= {24'h00_0000, d};
        avs_read <= rd;
        avs_write <= !rd;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        if (rd) chk(r & {24'hFF_FFFF, m}, {24'h00_0000, d});
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        bus(1'b1, 3'h3, 8'h03);
        bus(1'b1, 3'h4, 8'h00);
        bus(1'b1, 3'h5, 8'h01);
        bus(1'b0, 3'h0, 8'h55);
        bus(1'b0, 3'h3, 8'hBF);
        bus(1'b0, 3'h2, 8'h10);
        bus(1'b1, 3'h2, 8'h10);
        bus(1'b1, 3'h7, 8'h00);
        bus(1'b0, 3'h3, 8'h93);
        bus(1'b0, 3'h1, 8'h00);
        bus(1'b0, 3'h0, 8'h9C);
        bus(1'b0, 3'h7, 8'h10);
        bus(1'b1, 3'h0, 8'h9C);
        bus(1'b1, 3'h7, 8'h10);
        bus(1'b0, 3'h3, 8'h13);
        bus(1'b1, 3'h3, 8'h13);
        bus(1'b1, 3'h7, 8'h00);
        bus(1'b0, 3'h2, 8'h06);
        bus(1'b0, 3'h2, 8'h01);
        bus(1'b1, 3'h5, 8'h05, 8'h0D);
        bus(1'b0, 3'h0, 8'hAA);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        for (k = 0; k < 30000 && frames == 0; k++) @(posedge core_clk);
        chk(frames, 1);
        chk(rx_byte, 8'hAA);
        chk(stop_bit, 1'b1);
        chk(last_rise > 19984 && last_rise < 20016, 1'b1);
        wrap_up();
    end
endmodule // ubfs_uart_setup_test
`default_nettype wire
